// ==== hdl/cph_top.sv ====
// serial control port, pcm highways and multiplexed voice bus of the codec
// assumes: clk domain user logic; link logic on bit_clk, frame pulses synchronous to it
`timescale 1ns/1ps
module cph_top
  import cph_pkg::*;
(
  input  wire logic                                  clk,
  input  wire logic                                  nrst,
  input  wire logic                                  serial_ctrl_clock,
  input  wire logic                                  ctrl_chip_select_n,
  input  wire logic                                  ctrl_serial_in,
  output logic                                       ctrl_serial_out,
  output logic                                       ctrl_serial_out_en,
  output logic [CPH_BYTE_W-1:0]                      ctrl_byte,
  output logic                                       ctrl_byte_valid,
  input  wire logic [CPH_BYTE_W-1:0]                 resp_byte,
  input  wire logic                                  resp_valid,
  output logic                                       resp_taken,
  input  wire logic                                  data_format_select,
  input  wire logic                                  pcm_half_rate,
  input  wire logic                                  pcm_tx_falling,
  input  wire logic                                  pcm_rx_falling,
  input  wire logic [CPH_OFF_W-1:0]                  pcm_slot_offset,
  input  wire logic [CPH_CH-1:0][CPH_SLOT_W-1:0]     tx_slot_field,
  input  wire logic [CPH_CH-1:0][CPH_SLOT_W-1:0]     rx_slot_field,
  input  wire logic [CPH_CH-1:0]                     tx_highway_select,
  input  wire logic [CPH_CH-1:0]                     rx_highway_select,
  input  wire logic [CPH_CH-1:0][CPH_WORD_W-1:0]     tx_sample,
  output logic [CPH_CH-1:0][CPH_WORD_W-1:0]          rx_sample,
  input  wire logic [CPH_PAIRS-1:0][CPH_BYTE_W-1:0]  up_monitor,
  input  wire logic [CPH_PAIRS-1:0][CPH_SIG_W-1:0]   up_signal,
  input  wire logic [CPH_PAIRS-1:0]                  up_monitor_tx_flag_n,
  input  wire logic [CPH_PAIRS-1:0]                  up_monitor_rx_flag_n,
  output logic [CPH_PAIRS-1:0][CPH_BYTE_W-1:0]       dn_monitor,
  output logic [CPH_PAIRS-1:0][CPH_SIG_W-1:0]        dn_signal,
  output logic [CPH_PAIRS-1:0]                       dn_monitor_tx_flag_n,
  output logic [CPH_PAIRS-1:0]                       dn_monitor_rx_flag_n,
  output logic                                       frame_strobe,
  input  wire logic                                  bit_clk,
  input  wire logic                                  host_port_mode_pin,
  input  wire logic                                  slot_bank_select,
  input  wire logic                                  bus_double_rate,
  input  wire logic                                  pcm_frame_pulse,
  input  wire logic                                  bus_frame_pulse,
  output logic                                       pcm_tx_line_one,
  output logic                                       pcm_tx_line_one_en,
  output logic                                       pcm_tx_line_two,
  output logic                                       pcm_tx_line_two_en,
  input  wire logic                                  pcm_rx_line_one,
  input  wire logic                                  pcm_rx_line_two,
  output logic                                       upstream_line,
  output logic                                       upstream_line_en,
  input  wire logic                                  downstream_line
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [2:0]            sck;
    logic [1:0]            cs;
    logic [1:0]            md;
    logic [1:0]            sin;
    cph_sp_e               st;
    logic [2:0]            bc;
    logic [CPH_BYTE_W-1:0] si;
    logic [CPH_BYTE_W-1:0] so;
    logic                  bv;
    logic [CPH_BYTE_W-1:0] cb;
    logic                  rtk;
    logic [2:0]            ft;
    logic                  fstb;
    cph_cfg_s              h;
    cph_rx_s               r;
  } cph_sys_s;

  typedef struct packed {
    logic [1:0]            rsy;
    logic [1:0][2:0]       psy;
    logic                  fp_prev;
    logic [CPH_CNT_W-1:0]  cnt;
    logic                  tog;
    cph_cfg_s              c;
    cph_rx_s               rw;
    cph_rx_s               rh;
    logic                  d1;
    logic                  e1;
    logic                  d2;
    logic                  e2;
    logic                  up_q;
    logic                  up_e;
  } cph_lnk_s;

  cph_sys_s sy, next_sy;
  cph_lnk_s lk, next_lk;
  logic [2:0] neg_rx;
  logic [3:0] neg_tx;
  logic       rise, fall, csn, take, txb, sign_ref, bus, lin, half;
  cph_map_s   map_t, map_r;
  logic [11:0] pt, pr;

  // ==========================================================================
  // helpers
  function automatic logic [11:0] pos_dec(input logic [CPH_CNT_W-1:0] cnt,
                                          input logic [CPH_OFF_W-1:0] off,
                                          input logic                 hf);
    logic [CPH_CNT_W-1:0] d;
    d = cnt - CPH_CNT_W'(off);
    pos_dec = {cnt >= CPH_CNT_W'(off), hf ? d[10:1] : d[9:0], hf & d[0]};
  endfunction

  function automatic cph_map_s map_bit(input logic [CPH_BI_W-1:0]            bi,
                                       input logic                           bs,
                                       input logic                           ln,
                                       input logic                           bank,
                                       input logic [CPH_CH-1:0][CPH_SLOT_W-1:0] sf,
                                       input logic [CPH_CH-1:0]              hs);
    cph_map_s m;
    logic [CPH_SLOT_W-1:0] sl;
    logic [3:0] b;
    logic [1:0] by;
    m  = '0;
    sl = bi[9:3];
    b  = {1'b0, bi[2:0]};
    by = bi[4:3];
    if (!bs) begin
      for (int c = 0; c < CPH_CH; c++) begin
        if (sl == sf[c] || (ln && sl == sf[c] + 7'h1)) begin
          m.hit  = 1'b1;
          m.ch   = CPH_CH_W'(c);
          m.line = hs[c];
          m.idx  = (ln && sl == sf[c]) ? CPH_IDX_HI - b : CPH_IDX_LO - b;
        end
      end
    end else if (bi < CPH_BUS_BITS) begin
      m.hit = 1'b1;
      m.idx = CPH_IDX_LO - b;
      if (ln && bi[7] != bank) begin
        m.ch  = {bi[6:5], by[1]};
        m.idx = by[0] ? CPH_IDX_LO - b : CPH_IDX_HI - b;
      end else if (!ln && bi[7] != bank) begin
        m.hit = 1'b0;
      end else if (by == CPH_BY_MON) begin
        m.kind = CPH_K_MON;
        m.ch   = {1'b0, bi[6:5]};
      end else if (by == CPH_BY_SIG) begin
        m.kind = CPH_K_SIG;
        m.ch   = {1'b0, bi[6:5]};
      end else if (ln) begin
        m.kind = CPH_K_IDLE;
      end else begin
        m.ch = {bi[6:5], by[0]};
      end
    end
    return m;
  endfunction

  // ==========================================================================
  // serial control port and frame exchange, clk domain
  always_comb begin
    next_sy     = sy;
    next_sy.sck = {sy.sck[1:0], serial_ctrl_clock};
    next_sy.cs  = {sy.cs[0], ctrl_chip_select_n};
    next_sy.md  = {sy.md[0], host_port_mode_pin};
    next_sy.sin = {sy.sin[0], ctrl_serial_in};
    next_sy.ft  = {sy.ft[1:0], lk.tog};
    next_sy.bv  = 1'b0;
    next_sy.rtk = 1'b0;
    next_sy.fstb = 1'b0;
    rise = sy.sck[1] & ~sy.sck[2];
    fall = ~sy.sck[1] & sy.sck[2];
    csn  = sy.cs[1] | sy.md[1];
    if (csn) begin
      next_sy.st = CPH_SP_CMD;
      next_sy.bc = '0;
      next_sy.so = '0;
    end else begin
      if (rise) begin
        next_sy.bc = sy.bc + 3'h1;
        if (sy.st == CPH_SP_CMD) begin
          next_sy.si = {sy.si[6:0], sy.sin[1]};
          if (sy.bc == CPH_BIT_LAST) begin
            next_sy.bv = 1'b1;
            next_sy.cb = {sy.si[6:0], sy.sin[1]};
          end
        end
      end
      case (sy.st)
        CPH_SP_CMD: begin
          if (fall && sy.bc == '0 && resp_valid) begin
            next_sy.st  = CPH_SP_READ;
            next_sy.so  = resp_byte;
            next_sy.rtk = 1'b1;
          end
        end
        CPH_SP_READ: begin
          if (fall && sy.bc == '0) begin
            next_sy.st  = resp_valid ? CPH_SP_READ : CPH_SP_CMD;
            next_sy.so  = resp_valid ? resp_byte : '0;
            next_sy.rtk = resp_valid;
          end else if (fall) begin
            next_sy.so = {sy.so[6:0], 1'b0};
          end
        end
        default: next_sy.st = CPH_SP_CMD;
      endcase
    end
    // link holds its frame snapshot for a whole frame, so these words are stable here
    if (sy.ft[2] ^ sy.ft[1]) begin
      next_sy.fstb   = 1'b1;
      next_sy.r      = lk.rh;
      next_sy.h.lin  = data_format_select;
      next_sy.h.half = pcm_half_rate;
      next_sy.h.txf  = pcm_tx_falling;
      next_sy.h.rxf  = pcm_rx_falling;
      next_sy.h.off  = pcm_slot_offset;
      next_sy.h.tsf  = tx_slot_field;
      next_sy.h.rsf  = rx_slot_field;
      next_sy.h.tsel = tx_highway_select;
      next_sy.h.rsel = rx_highway_select;
      next_sy.h.tw   = tx_sample;
      next_sy.h.mon  = up_monitor;
      for (int p = 0; p < CPH_PAIRS; p++) begin
        next_sy.h.sig[p] = {up_signal[p], up_monitor_rx_flag_n[p], up_monitor_tx_flag_n[p]};
      end
    end
    if (!nrst) begin
      next_sy = '0;
    end
  end

  always_ff @(posedge clk) begin
    sy <= next_sy;
  end

  always_comb begin
    ctrl_serial_out    = sy.so[7];
    ctrl_serial_out_en = sy.st == CPH_SP_READ;
    ctrl_byte          = sy.cb;
    ctrl_byte_valid    = sy.bv;
    resp_taken         = sy.rtk;
    frame_strobe       = sy.fstb;
    rx_sample          = sy.r.w;
    dn_monitor         = sy.r.mon;
    for (int p = 0; p < CPH_PAIRS; p++) begin
      dn_signal[p]            = sy.r.sig[p][7:2];
      dn_monitor_rx_flag_n[p] = sy.r.sig[p][1];
      dn_monitor_tx_flag_n[p] = sy.r.sig[p][0];
    end
  end

  // ==========================================================================
  // highway and bus framing, bit_clk domain
  always_comb begin
    next_lk     = lk;
    next_lk.rsy = {lk.rsy[0], nrst};
    next_lk.psy = {lk.psy[0], {host_port_mode_pin, slot_bank_select, bus_double_rate}};
    bus  = lk.psy[1][2];
    lin  = lk.c.lin;
    half = bus ? lk.psy[1][0] : lk.c.half;
    next_lk.fp_prev = bus ? bus_frame_pulse : pcm_frame_pulse;
    if (next_lk.fp_prev && !lk.fp_prev) begin
      next_lk.cnt = '0;
      next_lk.tog = ~lk.tog;
      next_lk.c   = sy.h;
      next_lk.rh  = lk.rw;
    end else if (lk.cnt != CPH_CNT_MAX) begin
      next_lk.cnt = lk.cnt + 11'h1;
    end
    // transmit: bit for the position the counter moves to
    pt    = pos_dec(next_lk.cnt, bus ? '0 : lk.c.off, half);
    map_t = map_bit(pt[10:1], bus, lin, lk.psy[1][1], lk.c.tsf, lk.c.tsel);
    sign_ref = lk.c.tw[map_t.ch][CPH_IDX_SIGN];
    case (map_t.kind)
      CPH_K_VOICE: txb = (lin && map_t.idx >= CPH_IDX_COPY) ? sign_ref
                         : lk.c.tw[map_t.ch][map_t.idx];
      CPH_K_MON:   txb = lk.c.mon[map_t.ch[1:0]][map_t.idx[2:0]];
      CPH_K_SIG:   txb = lk.c.sig[map_t.ch[1:0]][map_t.idx[2:0]];
      default:     txb = 1'b1;
    endcase
    next_lk.d1   = txb;
    next_lk.d2   = txb;
    next_lk.up_q = txb;
    next_lk.e1   = ~bus & pt[11] & map_t.hit & ~map_t.line;
    next_lk.e2   = ~bus & pt[11] & map_t.hit & map_t.line;
    next_lk.up_e = bus & pt[11] & map_t.hit;
    // receive: bit of the position now ending
    pr    = pos_dec(lk.cnt, bus ? '0 : lk.c.off, half);
    map_r = map_bit(pr[10:1], bus, lin, lk.psy[1][1], lk.c.rsf, lk.c.rsel);
    take  = pr[11] & map_r.hit & (~half | pr[0]);
    if (take) begin
      case (map_r.kind)
        CPH_K_VOICE: next_lk.rw.w[map_r.ch][map_r.idx] = (bus | lk.c.rxf) ? neg_rx[2 - {1'b0, ~bus & ~map_r.line} - {1'b0, ~bus}]
                                                                           : (bus ? downstream_line : map_r.line ? pcm_rx_line_two
                                                                                                      : pcm_rx_line_one);
        CPH_K_MON:   next_lk.rw.mon[map_r.ch[1:0]][map_r.idx[2:0]] = neg_rx[2];
        CPH_K_SIG:   next_lk.rw.sig[map_r.ch[1:0]][map_r.idx[2:0]] = neg_rx[2];
        default:     next_lk.rw = lk.rw;
      endcase
    end
    if (!lk.rsy[1]) begin
      next_lk     = '0;
      next_lk.rsy = {lk.rsy[0], nrst};
      next_lk.psy = {lk.psy[0], {host_port_mode_pin, slot_bank_select, bus_double_rate}};
    end
  end

  always_ff @(posedge bit_clk) begin
    lk <= next_lk;
  end

  // falling-edge sample for the bus line and the selectable pcm edges, launch for the selectable pcm edges
  always_ff @(negedge bit_clk) begin
    neg_rx <= {downstream_line, pcm_rx_line_two, pcm_rx_line_one};
    if (!lk.rsy[1]) begin
      neg_tx <= '0;
    end else begin
      neg_tx <= {lk.d1, lk.e1, lk.d2, lk.e2};
    end
  end

  always_comb begin
    pcm_tx_line_one    = lk.c.txf ? neg_tx[3] : lk.d1;
    pcm_tx_line_one_en = lk.c.txf ? neg_tx[2] : lk.e1;
    pcm_tx_line_two    = lk.c.txf ? neg_tx[1] : lk.d2;
    pcm_tx_line_two_en = lk.c.txf ? neg_tx[0] : lk.e2;
    upstream_line      = lk.up_q;
    upstream_line_en   = lk.up_e;
  end

  // ==========================================================================
  // checks
  a_cs_abort: assert property (@(posedge clk) disable iff (!nrst)
    csn |=> sy.st == CPH_SP_CMD && sy.bc == '0 && !ctrl_serial_out)
    else $error("select high did not abort transfer");
  a_byte_whole: assert property (@(posedge clk) disable iff (!nrst)
    ctrl_byte_valid |-> sy.bc == '0 && $past(rise))
    else $error("byte delivered off a byte boundary");
  a_in_rise: assert property (@(posedge clk) disable iff (!nrst)
    (sy.si != $past(sy.si) && !$past(csn)) |-> $past(rise))
    else $error("input shifted without rising edge");
  a_out_fall: assert property (@(posedge clk) disable iff (!nrst)
    ($changed(ctrl_serial_out) && !$past(csn)) |-> $past(fall))
    else $error("output changed without falling edge");
  a_read_ignore: assert property (@(posedge clk) disable iff (!nrst)
    (sy.st == CPH_SP_READ && rise && !csn) |=> !ctrl_byte_valid && $stable(sy.si))
    else $error("command taken during read");
  a_mode_pcm: assert property (@(posedge bit_clk) disable iff (!lk.rsy[1])
    bus ##1 bus |-> !lk.e1 && !lk.e2)
    else $error("pcm line driven in bus mode");
  a_mode_bus: assert property (@(posedge bit_clk) disable iff (!lk.rsy[1])
    !bus ##1 !bus |-> !upstream_line_en)
    else $error("bus line driven in pcm mode");
  a_frame_zero: assert property (@(posedge bit_clk) disable iff (!lk.rsy[1])
    (next_lk.fp_prev && !lk.fp_prev) |=> lk.cnt == '0 && lk.tog != $past(lk.tog))
    else $error("frame pulse did not restart count");
  a_slot_offset: assert property (@(posedge bit_clk) disable iff (!lk.rsy[1])
    (!bus && lk.cnt < CPH_CNT_W'(lk.c.off) && $stable(lk.c)) |-> !lk.e1 && !lk.e2)
    else $error("pcm driven before slot offset");
  a_bus_length: assert property (@(posedge bit_clk) disable iff (!lk.rsy[1])
    (bus && $past(bus) && !half && lk.cnt >= CPH_CNT_W'(CPH_BUS_BITS)) |-> !upstream_line_en)
    else $error("bus driven beyond frame");
  a_lin_sign: assert property (@(posedge bit_clk) disable iff (!lk.rsy[1])
    (lin && map_t.kind == CPH_K_VOICE && map_t.idx >= CPH_IDX_COPY) |=> lk.d1 == $past(sign_ref))
    else $error("linear guard bits not sign copies");

  c_read_phase: cover property (@(posedge clk) disable iff (!nrst) resp_taken ##[1:400] resp_taken);
  c_bus_drive: cover property (@(posedge bit_clk) disable iff (!lk.rsy[1]) upstream_line_en && lin);
  c_pcm_two: cover property (@(posedge bit_clk) disable iff (!lk.rsy[1]) pcm_tx_line_two_en);
  c_frame_xfer: cover property (@(posedge clk) disable iff (!nrst) frame_strobe);
endmodule

// ==== hdl/cph_pkg.sv ====
// constants, field layouts and state types of the codec host interface block
// assumes: compiled before hdl/cph_top.sv
package cph_pkg;
  localparam int CPH_CH     = 8;
  localparam int CPH_CH_W   = $clog2(CPH_CH);
  localparam int CPH_PAIRS  = 4;
  localparam int CPH_BYTE_W = 8;
  localparam int CPH_WORD_W = 16;
  localparam int CPH_SLOT_W = 7;
  localparam int CPH_OFF_W  = 3;
  localparam int CPH_CNT_W  = 11;
  localparam int CPH_BI_W   = 10;
  localparam int CPH_SIG_W  = 6;

  localparam logic [10:0] CPH_CNT_MAX  = 11'h7ff;
  localparam logic [9:0]  CPH_BUS_BITS = 10'h100;
  localparam logic [2:0]  CPH_BIT_LAST = 3'h7;
  localparam logic [3:0]  CPH_IDX_HI   = 4'hf;
  localparam logic [3:0]  CPH_IDX_LO   = 4'h7;
  localparam logic [3:0]  CPH_IDX_COPY = 4'he;
  localparam logic [3:0]  CPH_IDX_SIGN = 4'hd;
  localparam logic [1:0]  CPH_BY_MON   = 2'h2;
  localparam logic [1:0]  CPH_BY_SIG   = 2'h3;

  typedef enum logic {CPH_SP_CMD, CPH_SP_READ} cph_sp_e;
  typedef enum logic [1:0] {CPH_K_VOICE, CPH_K_MON, CPH_K_SIG, CPH_K_IDLE} cph_kind_e;

  typedef struct packed {
    logic                                 lin;
    logic                                 half;
    logic                                 txf;
    logic                                 rxf;
    logic [CPH_OFF_W-1:0]                 off;
    logic [CPH_CH-1:0][CPH_SLOT_W-1:0]    tsf;
    logic [CPH_CH-1:0][CPH_SLOT_W-1:0]    rsf;
    logic [CPH_CH-1:0]                    tsel;
    logic [CPH_CH-1:0]                    rsel;
    logic [CPH_CH-1:0][CPH_WORD_W-1:0]    tw;
    logic [CPH_PAIRS-1:0][CPH_BYTE_W-1:0] mon;
    logic [CPH_PAIRS-1:0][CPH_BYTE_W-1:0] sig;
  } cph_cfg_s;

  typedef struct packed {
    logic [CPH_CH-1:0][CPH_WORD_W-1:0]    w;
    logic [CPH_PAIRS-1:0][CPH_BYTE_W-1:0] mon;
    logic [CPH_PAIRS-1:0][CPH_BYTE_W-1:0] sig;
  } cph_rx_s;

  typedef struct packed {
    logic                hit;
    cph_kind_e           kind;
    logic [CPH_CH_W-1:0] ch;
    logic [3:0]          idx;
    logic                line;
  } cph_map_s;
endpackage

// ==== tb/cph_far_end.sv ====
// far-end model: link clock, frame pulses and a loopback of every transmit line
// assumes: instantiated by the bench beside the codec; needs no reset
`timescale 1ns/1ps
module cph_far_end (
  output logic      bit_clk,
  output logic      pcm_frame_pulse,
  output logic      bus_frame_pulse,
  input  wire logic pcm_tx_line_one,
  input  wire logic pcm_tx_line_one_en,
  input  wire logic pcm_tx_line_two,
  input  wire logic pcm_tx_line_two_en,
  input  wire logic upstream_line,
  input  wire logic upstream_line_en,
  output logic      pcm_rx_line_one,
  output logic      pcm_rx_line_two,
  output logic      downstream_line
);
  int bit_cnt = 0;
  // ==========================================
  // link clock, 125 ns, phase unrelated to clk
  initial begin
    bit_clk = 1'b0;
    pcm_frame_pulse = 1'b0;
    bus_frame_pulse = 1'b0;
    #17;
    forever #62.5 bit_clk = ~bit_clk;
  end
  // ==========================================
  // frame pulse every 1000 link clocks
  always @(posedge bit_clk) begin
    bit_cnt <= (bit_cnt == 999) ? 0 : bit_cnt + 1;
    pcm_frame_pulse <= (bit_cnt == 999);
    bus_frame_pulse <= (bit_cnt == 999);
  end
  // ==========================================
  // loopback; a released line shows the inverse of its current data output
  assign pcm_rx_line_one = pcm_tx_line_one_en ? pcm_tx_line_one : ~pcm_tx_line_one;
  assign pcm_rx_line_two = pcm_tx_line_two_en ? pcm_tx_line_two : ~pcm_tx_line_two;
  assign downstream_line = upstream_line_en ? upstream_line : ~upstream_line;
endmodule

// ==== tb/cph_top_bench.sv ====
// bench of the codec host block: control bytes, pcm and bus frames in loopback
// assumes: cph_far_end loops every transmit line to the matching receive line
`timescale 1ns/1ps
module cph_top_bench
  import cph_pkg::*;
;
  logic clk, nrst, serial_ctrl_clock, ctrl_chip_select_n, ctrl_serial_in, resp_valid, resp_taken;
  logic ctrl_serial_out, ctrl_serial_out_en, ctrl_byte_valid, data_format_select, pcm_half_rate;
  logic pcm_tx_falling, pcm_rx_falling, frame_strobe, bit_clk, host_port_mode_pin, slot_bank_select;
  logic bus_double_rate, pcm_frame_pulse, bus_frame_pulse, pcm_tx_line_one, pcm_tx_line_one_en;
  logic pcm_tx_line_two, pcm_tx_line_two_en, pcm_rx_line_one, pcm_rx_line_two, upstream_line;
  logic upstream_line_en, downstream_line;
  logic [CPH_BYTE_W-1:0]                ctrl_byte, resp_byte;
  logic [CPH_OFF_W-1:0]                 pcm_slot_offset;
  logic [CPH_CH-1:0][CPH_SLOT_W-1:0]    tx_slot_field, rx_slot_field;
  logic [CPH_CH-1:0]                    tx_highway_select, rx_highway_select;
  logic [CPH_CH-1:0][CPH_WORD_W-1:0]    tx_sample, rx_sample, got;
  logic [CPH_PAIRS-1:0][CPH_BYTE_W-1:0] up_monitor, dn_monitor;
  logic [CPH_PAIRS-1:0][CPH_SIG_W-1:0]  up_signal, dn_signal;
  logic [CPH_PAIRS-1:0]                 up_monitor_tx_flag_n, up_monitor_rx_flag_n;
  logic [CPH_PAIRS-1:0]                 dn_monitor_tx_flag_n, dn_monitor_rx_flag_n;
  logic [31:0]                          seed = 32'h7323;
  logic [192:0]                         e;
  logic [7:0]                           ctl_q[$];
  logic [192:0]                         frm_q[$];
  int                                   n_mismatch = 0;
  int                                   cmp_count = 0;

  cph_top u_dut (.*);
  cph_far_end u_far (.bit_clk(bit_clk), .pcm_frame_pulse(pcm_frame_pulse), .bus_frame_pulse(bus_frame_pulse),
    .pcm_tx_line_one(pcm_tx_line_one), .pcm_tx_line_one_en(pcm_tx_line_one_en),
    .pcm_tx_line_two(pcm_tx_line_two), .pcm_tx_line_two_en(pcm_tx_line_two_en),
    .upstream_line(upstream_line), .upstream_line_en(upstream_line_en), .pcm_rx_line_one(pcm_rx_line_one),
    .pcm_rx_line_two(pcm_rx_line_two), .downstream_line(downstream_line));

  // ==========================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] x);
    cmp_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic chk_frame(input logic [127:0] g, input logic [127:0] x);
    cmp_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic report_and_stop;
    if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==========================================
  // host side of the control port, 320 ns clock
  task automatic ctl_bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      repeat (4) @(posedge clk);
      serial_ctrl_clock <= 1'b0;
      ctrl_serial_in <= b[i];
      repeat (4) @(posedge clk);
      serial_ctrl_clock <= 1'b1;
    end
  endtask
  task automatic ctl_end;
    repeat (4) @(posedge clk);
    ctrl_chip_select_n <= 1'b1;
    repeat (4) @(posedge clk);
    serial_ctrl_clock <= 1'b0;
    repeat (4) @(posedge clk);
    serial_ctrl_clock <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  // response bytes clocked out while command bits are offered and must be ignored
  task automatic ctl_read(input logic [7:0] r);
    logic [7:0] g;
    resp_byte <= r;
    resp_valid <= 1'b1;
    for (int i = 7; i >= 0; i--) begin
      repeat (4) @(posedge clk);
      serial_ctrl_clock <= 1'b0;
      ctrl_serial_in <= 1'b1;
      repeat (4) @(posedge clk);
      resp_valid <= 1'b0;
      serial_ctrl_clock <= 1'b1;
      g[i] = ctrl_serial_out;
    end
    chk_byte(g, r);
  endtask
  // ==========================================
  // one frame scenario; expectation noted once the setting has crossed
  task automatic run_frames(input logic bus, lin, half, bank, hs, input logic [2:0] off);
    logic [192:0] x;
    @(posedge clk);
    host_port_mode_pin <= bus;
    data_format_select <= lin;
    ctrl_chip_select_n <= bus ? lin : 1'b1;
    pcm_half_rate <= half;
    pcm_tx_falling <= half;
    pcm_rx_falling <= half;
    bus_double_rate <= half;
    pcm_slot_offset <= off;
    slot_bank_select <= bank;
    tx_highway_select <= {CPH_CH{hs}};
    rx_highway_select <= {CPH_CH{hs}};
    x = '0;
    x[192] = bus;
    for (int i = 0; i < CPH_CH; i++) begin
      seed = lfsr(seed);
      tx_sample[i] <= seed[15:0];
      tx_slot_field[i] <= 7'(lin ? 8 + 2 * i : 8 + i);
      rx_slot_field[i] <= 7'(lin ? 8 + 2 * i : 8 + i);
      x[16*i +: 16] = lin ? {{2{seed[13]}}, seed[13:0]} : {8'h00, seed[7:0]};
    end
    seed = lfsr(seed);
    up_monitor <= seed;
    x[191:160] = seed;
    seed = lfsr(seed);
    up_signal <= seed[31:8];
    up_monitor_rx_flag_n <= seed[7:4];
    up_monitor_tx_flag_n <= seed[3:0];
    x[159:128] = seed;
    repeat (3) @(posedge clk iff frame_strobe === 1'b1);
    @(posedge clk);
    frm_q.push_back(x);
    @(posedge clk iff frame_strobe === 1'b1);
    @(posedge clk);
  endtask
  // ==========================================
  // result watchers
  always @(posedge clk) begin
    if (ctrl_byte_valid === 1'b1) chk_byte(ctrl_byte, ctl_q.size() ? ctl_q.pop_front() : 8'bx);
    if (resp_taken === 1'b1) chk_byte({ctrl_serial_out_en, 6'h0, ctrl_serial_out}, {1'b1, 6'h0, resp_byte[7]});
    if (frame_strobe === 1'b1 && frm_q.size() > 0) begin
      e = frm_q.pop_front();
      got = rx_sample;
      for (int i = 0; i < CPH_CH; i++) if (data_format_select === 1'b0) got[i][15:8] = 8'h00;
      chk_frame(got, e[127:0]);
      if (e[192]) chk_frame({64'h0, dn_monitor, dn_signal, dn_monitor_rx_flag_n, dn_monitor_tx_flag_n},
                            {64'h0, e[191:128]});
    end
  end
  // ==========================================
  // clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    {nrst, ctrl_serial_in, resp_valid, data_format_select, pcm_half_rate, pcm_tx_falling} = '0;
    {pcm_rx_falling, host_port_mode_pin, slot_bank_select, bus_double_rate} = '0;
    {serial_ctrl_clock, ctrl_chip_select_n} = 2'h3;
    {resp_byte, pcm_slot_offset, tx_slot_field, rx_slot_field, tx_highway_select, rx_highway_select} = '0;
    {tx_sample, up_monitor, up_signal, up_monitor_tx_flag_n, up_monitor_rx_flag_n} = '0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    ctrl_chip_select_n <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      ctl_bits(seed[7:0], 8);
      ctl_q.push_back(seed[7:0]);
    end
    ctl_bits(8'ha5, 5);
    ctl_end();
    ctrl_chip_select_n <= 1'b0;
    seed = lfsr(seed);
    ctl_bits(seed[7:0], 8);
    ctl_q.push_back(seed[7:0]);
    ctl_end();
    ctrl_chip_select_n <= 1'b0;
    seed = lfsr(seed);
    ctl_bits(seed[7:0], 8);
    ctl_q.push_back(seed[7:0]);
    seed = lfsr(seed);
    ctl_read(seed[7:0]);
    ctl_end();
    run_frames(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0);
    run_frames(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 3'h7);
    run_frames(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0);
    run_frames(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 3'h0);
    report_and_stop();
  end
endmodule
